// *** common/pin_ctrl_cfg.svh ***
// Purpose: Constants for the shared pin function control block.
// Assumes: 32-bit Avalon-MM register bus, word-aligned byte addresses.
// Notes: Field positions and reset values are named here once.
`ifndef PIN_CTRL_CFG_SVH
`define PIN_CTRL_CFG_SVH
`define ADDR_SYS_OPT 8'h00
`define ADDR_PULL_EN 8'h04
`define ADDR_SLEW_EN 8'h08
`define ADDR_DRIVE_SEL 8'h0C
`define ADDR_KEYPAD 8'h10
`define ADDR_PIN_MUX 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_FORCE_RST 8'h1C
`define BIT_DEBUG_PE 0
`define BIT_RESET_PE 1
`define BIT_IRQ_PE 2
`define BIT_IRQ_PDD 3
`define BIT_IRQ_EDGE 4
`define BIT_CAPTURE 0
`define BIT_CMP_OUT 1
`define BIT_OUT_EN 2
`define RESET_SLEW 6'h20
`define RESET_DRIVE 6'h00
`endif

// *** common/pin_ctrl_pkg.sv ***
// Purpose: Types for the shared pin function control block.
// Assumes: Six pins, pin 5 input-only shared pin, pin 4 debug pin.
// Notes: Pad controls travel as one packed struct per pin group.
package pin_ctrl_pkg;
   typedef struct packed {
      logic [5:0] pull_up;
      logic [5:0] pull_down;
      logic [5:0] high_drive;
      logic [5:0] slew_on;
   } pad_ctrl_t;
   typedef enum logic [1:0] {
      MODE_RUN = 2'b01,
      MODE_BACKGROUND = 2'b10
   } run_mode_t;
endpackage

// *** hw/shared_pin_function_control.sv ***
// Purpose: Pin function and pad configuration control for two shared pins.
// Assumes: Avalon-MM slave on mclk, pin inputs asynchronous to mclk.
// Notes: Function
// Function
// [RQ1] Irq pin pull device, selectable up/down.
// [RQ2] Reset pin function enables its pullup.
// [RQ3] Debug pin enable turns on pullup.
// [RQ4] Keypad edge select flips pullup to pulldown.
// [RQ5] All registers clocked by bus clock.
// [RQ6] User-mode power-on: shared pin is input.
// [RQ7] Reset pin function sticks until power-on.
// [RQ8] Low on reset pin resets device.
// [RQ9] Background power-on: shared pin is reset.
// [RQ10] Timer capture mode routes shared pin.
// [RQ11] Debug pin: mode select then debug.
// [RQ12] Every reset sets debug pin enable.
// [RQ13] Debug pin level picks run mode.
// [RQ14] Debug bit lasts sixteen debug clocks.
// [RQ15] Debug pin is pseudo open-drain.
// [RQ16] Software picks drive, slew, pullup.
// [RQ17] After reset inputs float, pullups off.
// [RQ18] Output-only pin: off, low drive, slew. Reset slew is set on pin 5, not on the output pin 4.
// [RQ19] Software should not leave inputs floating.
// [RQ20] Reset pin resets into user mode only; here the debug pin picks the mode, as after any reset.
// [RQ21] Outputs and analog pins lose pullup.
// [RQ22] Rising-edge detection makes pulldown.
`timescale 1ns/1ps
`include "pin_ctrl_cfg.svh"
module shared_pin_function_control #(
   parameter int PINS = 6
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic por_reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] port_dir_out,
   input wire logic [PINS-1:0] periph_out,
   input wire logic [PINS-1:0] analog_claim,
   input wire logic debug_drive_low,
   input wire logic debug_speedup,
   input wire logic timer_compare_level,
   input wire logic port_out_level,
   output pin_ctrl_pkg::pad_ctrl_t pad_ctrl,
   output logic debug_pin_out,
   output logic debug_pin_oe,
   output logic out_pin_level,
   output logic out_pin_oe,
   output logic shared_reset_req,
   output logic timer_capture_in,
   output logic irq_in,
   output logic shared_port_in,
   output logic background_mode
);
   import pin_ctrl_pkg::*;

   // Pins 4 and 5 are the two shared pins; pins 0 to 3 may serve the keypad.
   // The pad struct is registered, so a change shows one edge after its cause.

   // Two-stage synchronisers for the pins; the first stage feeds only the second.
   logic [PINS-1:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;

   // Soft registers.
   // They hold the configuration that software sees, plus the mode picked at reset.
   logic debug_pe_r, debug_pe_nxt;
   logic reset_pe_r, reset_pe_nxt;
   logic irq_pe_r, irq_pe_nxt;
   logic irq_pdd_r, irq_pdd_nxt;
   logic irq_edge_r, irq_edge_nxt;
   logic [PINS-1:0] pull_en_r, pull_en_nxt;
   logic [PINS-1:0] slew_r, slew_nxt;
   logic [PINS-1:0] drive_r, drive_nxt;
   logic [3:0] kbi_pe_r, kbi_pe_nxt;
   logic [3:0] kbi_edge_r, kbi_edge_nxt;
   logic capture_r, capture_nxt;
   logic cmp_out_r, cmp_out_nxt;
   logic out_en_r, out_en_nxt;
   logic force_rst_r, force_rst_nxt;
   logic mode_sampled_r, mode_sampled_nxt;
   run_mode_t mode_r, mode_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic wait_r, wait_nxt;
   pad_ctrl_t pad_r, pad_nxt;
   logic dbg_out_r, dbg_out_nxt, dbg_oe_r, dbg_oe_nxt;
   logic opin_r, opin_nxt, opin_oe_r, opin_oe_nxt;
   logic rst_req_r, rst_req_nxt;
   logic cap_r, cap_nxt, irq_r, irq_nxt, port_r, port_nxt;
   logic wr_hit, rd_hit;

   // Bus handshake.
   //
   // Accesses complete in two cycles: waitrequest drops one cycle after the request.
   // Read data are registered at the edge that takes the request, so they stand
   // for exactly the cycle in which waitrequest is low.
   // Writes land at the closing edge, where waitrequest is sampled low.
   // The fixed wait state costs a cycle per access but keeps the read path registered.
   always_comb begin
      sync1_nxt = pin_in;
      sync2_nxt = sync1_r;
      wait_nxt = 1'b1;
      if ((avs_read || avs_write) && wait_r) begin
         wait_nxt = 1'b0;
      end
   end

   // Write strobe: the closing edge of the access.
   assign wr_hit = avs_write && !wait_r;
   // Read capture: the opening edge, so data stand while waitrequest is low.
   assign rd_hit = avs_read && wait_r;

   // Register file.
   //
   // Every flop here runs on the bus clock. RQ5
   // Only the low bits of each word are defined; the rest read back as zero.
   // Software can set the reset-pin enable but never clear it. Clearing it could hand a
   // reset line back to the port while a board circuit still pulls on it.
   always_comb begin
      debug_pe_nxt = debug_pe_r;
      reset_pe_nxt = reset_pe_r;
      irq_pe_nxt = irq_pe_r;
      irq_pdd_nxt = irq_pdd_r;
      irq_edge_nxt = irq_edge_r;
      pull_en_nxt = pull_en_r;
      slew_nxt = slew_r;
      drive_nxt = drive_r;
      kbi_pe_nxt = kbi_pe_r;
      kbi_edge_nxt = kbi_edge_r;
      capture_nxt = capture_r;
      cmp_out_nxt = cmp_out_r;
      out_en_nxt = out_en_r;
      force_rst_nxt = 1'b0;
      mode_sampled_nxt = 1'b1;
      mode_nxt = mode_r;
      // Mode picked from the debug pin at the first edge after reset release.
      // The synchronisers run through reset, so this is the level the pod held
      // while reset was active, two edges late.
      if (!mode_sampled_r) begin
         mode_nxt = sync2_r[4] ? MODE_RUN : MODE_BACKGROUND; // [RQ13]
         // The reset pin should lead only into user mode [RQ20]; reset has already cleared rst_req_r here, so the debug pin decides.
         if (rst_req_r) begin
            mode_nxt = MODE_RUN;
         end
         // Background entry after any reset, power-on or plain, defaults the shared pin to reset. [RQ9]
         // Without it a pod could never reset the part again after a stuck program.
         if (!sync2_r[4] && !rst_req_r) begin
            reset_pe_nxt = 1'b1;
         end
      end
      if (wr_hit) begin
         if (avs_address == `ADDR_SYS_OPT) begin
            debug_pe_nxt = avs_writedata[`BIT_DEBUG_PE];
            // Once set, the reset function holds until power-on. [RQ7]
            reset_pe_nxt = reset_pe_r | avs_writedata[`BIT_RESET_PE];
            irq_pe_nxt = avs_writedata[`BIT_IRQ_PE];
            irq_pdd_nxt = avs_writedata[`BIT_IRQ_PDD];
            irq_edge_nxt = avs_writedata[`BIT_IRQ_EDGE];
         end else if (avs_address == `ADDR_PULL_EN) begin
            pull_en_nxt = avs_writedata[PINS-1:0]; // [RQ16]
         end else if (avs_address == `ADDR_SLEW_EN) begin
            slew_nxt = avs_writedata[PINS-1:0];
         end else if (avs_address == `ADDR_DRIVE_SEL) begin
            drive_nxt = avs_writedata[PINS-1:0];
         end else if (avs_address == `ADDR_KEYPAD) begin
            kbi_pe_nxt = avs_writedata[3:0];
            kbi_edge_nxt = avs_writedata[7:4];
         end else if (avs_address == `ADDR_PIN_MUX) begin
            capture_nxt = avs_writedata[`BIT_CAPTURE];
            cmp_out_nxt = avs_writedata[`BIT_CMP_OUT];
            out_en_nxt = avs_writedata[`BIT_OUT_EN];
         end else if (avs_address == `ADDR_FORCE_RST) begin
            // A one-cycle pulse; it reaches the reset request one edge later.
            force_rst_nxt = avs_writedata[0]; // [RQ20]
         end
      end
   end

   // Read data and status.
   //
   // The status word shows the synchronised pins and, in bit 8, the mode.
   // Reads have no side effect, so software may poll any address safely.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (rd_hit) begin
         if (avs_address == `ADDR_SYS_OPT) begin
            rdata_nxt[`BIT_DEBUG_PE] = debug_pe_r;
            rdata_nxt[`BIT_RESET_PE] = reset_pe_r;
            rdata_nxt[`BIT_IRQ_PE] = irq_pe_r;
            rdata_nxt[`BIT_IRQ_PDD] = irq_pdd_r;
            rdata_nxt[`BIT_IRQ_EDGE] = irq_edge_r;
         end else if (avs_address == `ADDR_PULL_EN) begin
            rdata_nxt[PINS-1:0] = pull_en_r;
         end else if (avs_address == `ADDR_SLEW_EN) begin
            rdata_nxt[PINS-1:0] = slew_r;
         end else if (avs_address == `ADDR_DRIVE_SEL) begin
            rdata_nxt[PINS-1:0] = drive_r;
         end else if (avs_address == `ADDR_KEYPAD) begin
            rdata_nxt[7:0] = {kbi_edge_r, kbi_pe_r};
         end else if (avs_address == `ADDR_PIN_MUX) begin
            rdata_nxt[2:0] = {out_en_r, cmp_out_r, capture_r};
         end else if (avs_address == `ADDR_STATUS) begin
            rdata_nxt[PINS-1:0] = sync2_r;
            rdata_nxt[8] = (mode_r == MODE_BACKGROUND);
         end
      end
   end

   // Pad control.
   //
   // Pull direction, drive and slew per pin. The pull is only offered while the
   // pin is an input; once port logic, a peripheral or an analog function claims
   // the pin, the pull goes away whatever the enable bit says.
   // Drive and slew pass through; they only matter while the pad drives.
   // The shared pins' own rules come last, so the owning function wins.
   always_comb begin
      pad_nxt.high_drive = drive_r; // [RQ16]
      pad_nxt.slew_on = slew_r;
      pad_nxt.pull_up = '0;
      pad_nxt.pull_down = '0;
      for (int i = 0; i < PINS; i++) begin
         // Outputs and analog-claimed pins get no pull here; the shared-pin rules below can still add one. [RQ21]
         if (pull_en_r[i] && !port_dir_out[i] && !periph_out[i] && !analog_claim[i]) begin
            pad_nxt.pull_up[i] = 1'b1;
            // Keypad rising-edge select swaps to pulldown. [RQ4] [RQ22]
            // A pullup on a rising-edge input would hold it at the active level.
            if (i < 4 && kbi_pe_r[i % 4] && kbi_edge_r[i % 4]) begin
               pad_nxt.pull_up[i] = 1'b0;
               pad_nxt.pull_down[i] = 1'b1;
            end
         end
      end
      // Shared pin 5: reset function forces pullup, irq uses its own pull. [RQ2]
      if (reset_pe_r) begin
         pad_nxt.pull_up[5] = 1'b1;
         pad_nxt.pull_down[5] = 1'b0;
      end else if (irq_pe_r) begin
         pad_nxt.pull_up[5] = !irq_pdd_r && !irq_edge_r; // [RQ1]
         pad_nxt.pull_down[5] = !irq_pdd_r && irq_edge_r; // [RQ22]
      end
      // Debug pin gets its pullup while the debug function owns it. [RQ3]
      if (debug_pe_r) begin
         pad_nxt.pull_up[4] = 1'b1;
         pad_nxt.pull_down[4] = 1'b0;
      end
   end

   // Pin functions.
   //
   // The debug pin is pulled up, pulled low by the debug engine and only given
   // short active-high speedup pulses.
   // The shared pin feeds port, interrupt and capture only while it is not the
   // reset input. Every path reads the second synchroniser stage.
   always_comb begin
      // Pseudo open-drain: drive low, or a brief active-high speedup pulse. [RQ15] [RQ14]
      dbg_out_nxt = debug_speedup && !debug_drive_low;
      dbg_oe_nxt = debug_pe_r && (debug_drive_low || debug_speedup); // [RQ11]
      // Alternate output on the debug pin needs debug enable cleared. [RQ12]
      opin_nxt = cmp_out_r ? timer_compare_level : port_out_level;
      opin_oe_nxt = !debug_pe_r && out_en_r; // [RQ18]
      rst_req_nxt = reset_pe_r && !sync2_r[5]; // [RQ8]
      cap_nxt = capture_r && !reset_pe_r && sync2_r[5]; // [RQ10]
      irq_nxt = irq_pe_r && !reset_pe_r && sync2_r[5];
      port_nxt = !reset_pe_r && sync2_r[5]; // [RQ6]
   end

   // Main register bank.
   //
   // A plain reset restores every soft register but the reset-pin enable.

   // Soft reset does not clear the reset-pin function; only power-on does. [RQ7] [RQ12]
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         debug_pe_r <= 1'b1;
         irq_pe_r <= 1'b0;
         irq_pdd_r <= 1'b0;
         irq_edge_r <= 1'b0;
         pull_en_r <= '0; // [RQ17]
         slew_r <= `RESET_SLEW; // [RQ18]
         drive_r <= `RESET_DRIVE;
         kbi_pe_r <= 4'h0;
         kbi_edge_r <= 4'h0;
         capture_r <= 1'b0;
         cmp_out_r <= 1'b0;
         out_en_r <= 1'b0;
         force_rst_r <= 1'b0;
         mode_sampled_r <= 1'b0;
         mode_r <= MODE_RUN;
         rdata_r <= 32'h0000_0000;
         wait_r <= 1'b1;
         pad_r <= '0;
         dbg_out_r <= 1'b0;
         dbg_oe_r <= 1'b0;
         opin_r <= 1'b0;
         opin_oe_r <= 1'b0;
         rst_req_r <= 1'b0;
         cap_r <= 1'b0;
         irq_r <= 1'b0;
         port_r <= 1'b0;
      end else begin
         debug_pe_r <= debug_pe_nxt;
         irq_pe_r <= irq_pe_nxt;
         irq_pdd_r <= irq_pdd_nxt;
         irq_edge_r <= irq_edge_nxt;
         pull_en_r <= pull_en_nxt;
         slew_r <= slew_nxt;
         drive_r <= drive_nxt;
         kbi_pe_r <= kbi_pe_nxt;
         kbi_edge_r <= kbi_edge_nxt;
         capture_r <= capture_nxt;
         cmp_out_r <= cmp_out_nxt;
         out_en_r <= out_en_nxt;
         force_rst_r <= force_rst_nxt;
         mode_sampled_r <= mode_sampled_nxt;
         mode_r <= mode_nxt;
         rdata_r <= rdata_nxt;
         wait_r <= wait_nxt;
         pad_r <= pad_nxt;
         dbg_out_r <= dbg_out_nxt;
         dbg_oe_r <= dbg_oe_nxt;
         opin_r <= opin_nxt;
         opin_oe_r <= opin_oe_nxt;
         rst_req_r <= rst_req_nxt | force_rst_r;
         cap_r <= cap_nxt;
         irq_r <= irq_nxt;
         port_r <= port_nxt;
      end
   end

   // Pin synchronisers.
   //
   // No reset on purpose: they keep sampling while reset is held, so the second
   // stage already shows the real debug pin level when reset lets go. A reset
   // value would look like a low debug pin and force background mode.
   always_ff @(posedge mclk) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
   end

   // The reset-pin function is cleared only by power-on reset. [RQ7]
   // Power-on reset must be asserted together with the plain reset.
   always_ff @(posedge mclk or posedge por_reset) begin
      if (por_reset) begin
         reset_pe_r <= 1'b0;
      end else begin
         reset_pe_r <= reset_pe_nxt;
      end
   end

   // Outputs.
   //
   // Every output is a flop; background_mode compares both bits of the one-hot mode flop.

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign pad_ctrl = pad_r;
   assign debug_pin_out = dbg_out_r;
   assign debug_pin_oe = dbg_oe_r;
   assign out_pin_level = opin_r;
   assign out_pin_oe = opin_oe_r;
   assign shared_reset_req = rst_req_r;
   assign timer_capture_in = cap_r;
   assign irq_in = irq_r;
   assign shared_port_in = port_r;
   assign background_mode = (mode_r == MODE_BACKGROUND);
endmodule

// *** testbench/pin_ctrl_props.sv ***
// Purpose: Port assertions for the shared pin function control.
// Assumes: One bus clock; helper flags shadow register writes.
// Notes: Reset pin flag clears only on power-on reset.
`timescale 1ns/1ps
module pin_ctrl_props #(
   parameter int PINS = 6
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic por_reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic avs_waitrequest,
   input wire logic [PINS-1:0] pin_in,
   input wire logic [PINS-1:0] port_dir_out,
   input wire logic [PINS-1:0] periph_out,
   input wire logic [PINS-1:0] analog_claim,
   input wire pin_ctrl_pkg::pad_ctrl_t pad_ctrl,
   input wire logic out_pin_oe,
   input wire logic shared_reset_req,
   input wire logic timer_capture_in,
   input wire logic background_mode
);
   import pin_ctrl_pkg::*;
   logic wr_ok, rst_fn_r, rst_fn_nxt, cap_r, cap_nxt;
   assign wr_ok = avs_write && !avs_waitrequest;
   always_comb begin
      rst_fn_nxt = rst_fn_r | (wr_ok && avs_address == 8'h00 && avs_writedata[1]);
      cap_nxt = (wr_ok && avs_address == 8'h14) ? avs_writedata[0] : cap_r;
   end
   // A plain reset must not clear the flag, since the pin function outlives it.
   always_ff @(posedge mclk or posedge por_reset) begin
      if (por_reset) rst_fn_r <= 1'b0;
      else rst_fn_r <= rst_fn_nxt;
   end
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) cap_r <= 1'b0;
      else cap_r <= cap_nxt;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   bus_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer is not a single cycle");
   reset_pullup_a: assert property (
      $past(rst_fn_r, 2) && !$past(reset, 2) |-> pad_ctrl.pull_up[5])
      else $error("reset pin has no pullup");
   pin_reset_a: assert property (
      (rst_fn_r && !pin_in[5])[*4] |-> shared_reset_req)
      else $error("low reset pin gives no reset");
   debug_pullup_a: assert property (
      $fell(reset) |-> ##[0:2] pad_ctrl.pull_up[4])
      else $error("debug pin pullup missing after reset");
   pad_default_a: assert property (
      $fell(reset) |-> ##1 pad_ctrl.slew_on == 6'h20 && pad_ctrl.high_drive == 6'h00
      && !out_pin_oe && (pad_ctrl.pull_up & 6'h0F) == 6'h00)
      else $error("pad defaults wrong after reset");
   pull_off_a: assert property (
      !$past(reset) |-> ($past(port_dir_out | periph_out | analog_claim) & pad_ctrl.pull_up) == 0)
      else $error("pullup kept on a driven pin");
   capture_route_a: assert property (
      (cap_r && $stable(pin_in[5]))[*4] |-> timer_capture_in == pin_in[5])
      else $error("capture input not routed");
   mode_pick_a: assert property (
      $fell(reset) && $past(pin_in[4]) == pin_in[4] |-> ##3 background_mode == !$past(pin_in[4], 3))
      else $error("run mode not picked by debug pin");
endmodule
bind shared_pin_function_control pin_ctrl_props #(.PINS(PINS)) pin_ctrl_props_inst (.mclk,
   .reset, .por_reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest,
   .pin_in, .port_dir_out, .periph_out, .analog_claim, .pad_ctrl, .out_pin_oe,
   .shared_reset_req, .timer_capture_in, .background_mode);

// *** testbench/board_pod_model.sv ***
// Purpose: Board and debug pod that sit on the two shared pins.
// Assumes: Board resistor pulls the debug line high when nobody drives it.
// Notes: An undriven shared pin without pullup toggles every cycle.
`timescale 1ns/1ps
module board_pod_model (
   input wire logic mclk,
   input wire logic debug_pin_out,
   input wire logic debug_pin_oe,
   input wire pin_ctrl_pkg::pad_ctrl_t pad_ctrl,
   input wire logic hold_low,
   input wire logic sh_drive,
   input wire logic sh_level,
   output logic dbg_wire,
   output logic shared_wire
);
   import pin_ctrl_pkg::*;
   logic churn_r = 1'b0;
   always @(posedge mclk) churn_r <= ~churn_r;
   always_comb begin
      if (debug_pin_oe) dbg_wire = debug_pin_out;
      else dbg_wire = !hold_low;
      if (sh_drive) shared_wire = sh_level;
      else shared_wire = pad_ctrl.pull_up[5] | churn_r;
   end
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the shared pin function control.
// Assumes: Bus master waits for waitrequest low before releasing.
// Notes: Pad outputs are sampled a few cycles after each change.
`timescale 1ns/1ps
module testbench;
   import pin_ctrl_pkg::*;
   logic mclk, avs_waitrequest, dbg_wire, shared_wire, debug_pin_out, debug_pin_oe;
   logic reset = 1'b1, por_reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [5:0] pin_in, port_dir_out = 6'h00, periph_out = 6'h00, analog_claim = 6'h00;
   logic debug_drive_low = 1'b0, debug_speedup = 1'b0, hold_low = 1'b0;
   logic sh_drive = 1'b1, sh_level = 1'b1, timer_compare_level = 1'b0, port_out_level = 1'b0;
   logic shared_reset_req, timer_capture_in, irq_in, shared_port_in, background_mode;
   logic out_pin_level, out_pin_oe;
   pad_ctrl_t pad_ctrl;
   int num_errors = 0;
   int samples_checked = 0;
   assign pin_in = {shared_wire, dbg_wire, 4'h5};
   shared_pin_function_control shared_pin_function_control_inst (.mclk, .reset, .por_reset,
      .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .pin_in, .port_dir_out, .periph_out, .analog_claim, .debug_drive_low, .debug_speedup,
      .timer_compare_level, .port_out_level, .pad_ctrl, .debug_pin_out, .debug_pin_oe,
      .out_pin_level, .out_pin_oe, .shared_reset_req, .timer_capture_in, .irq_in,
      .shared_port_in, .background_mode);
   board_pod_model board_pod_model_inst (.mclk, .debug_pin_out, .debug_pin_oe, .pad_ctrl,
      .hold_low, .sh_drive, .sh_level, .dbg_wire, .shared_wire);
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // The request is held until waitrequest is sampled low; no latency is assumed.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) chk("bus answer", 0, 1);
   endtask
   task automatic do_reset(input logic por);
      @(posedge mclk);
      reset <= 1'b1;
      por_reset <= por;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      por_reset <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
   task automatic t_defaults;
      chk("pull_up", 6'h10, pad_ctrl.pull_up);
      chk("slew and drive", 12'h800, {pad_ctrl.slew_on, pad_ctrl.high_drive});
      chk("out_pin_oe", 1'b0, out_pin_oe);
      chk("background_mode", 1'b0, background_mode);
      bus(1'b0, 8'h00, 32'h0);
      chk("sys options", 32'h1, rd);
      chk("shared_port_in", 1'b1, shared_port_in);
   endtask
   task automatic t_pads;
      bus(1'b1, 8'h04, 32'h3F);
      bus(1'b1, 8'h08, 32'h15);
      bus(1'b1, 8'h0C, 32'h2A);
      port_dir_out <= 6'h01;
      periph_out <= 6'h02;
      analog_claim <= 6'h04;
      repeat (3) @(posedge mclk);
      chk("pull_up", 6'h38, pad_ctrl.pull_up);
      chk("slew and drive", 12'h56A, {pad_ctrl.slew_on, pad_ctrl.high_drive});
      bus(1'b1, 8'h40, 32'hFF);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped read", 32'h0, rd);
      port_dir_out <= 6'h00;
      periph_out <= 6'h00;
      analog_claim <= 6'h00;
   endtask
   task automatic t_keypad_irq;
      logic [31:0] opt [3] = '{32'h04, 32'h14, 32'h0C};
      logic [11:0] want [3] = '{12'h801, 12'h021, 12'h001};
      bus(1'b1, 8'h04, 32'h21);
      bus(1'b1, 8'h10, 32'h11);
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, 8'h00, opt[i]);
         repeat (3) @(posedge mclk);
         chk("pull up down", want[i], {pad_ctrl.pull_up, pad_ctrl.pull_down});
         chk("irq_in", 1'b1, irq_in);
      end
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h10, 32'h0);
   endtask
   task automatic t_capture;
      bus(1'b1, 8'h14, 32'h1);
      for (int i = 0; i < 2; i++) begin
         sh_level <= i[0];
         repeat (5) @(posedge mclk);
         chk("timer_capture_in", i[0], timer_capture_in);
      end
      bus(1'b1, 8'h14, 32'h0);
   endtask
   task automatic t_reset_pin;
      bus(1'b1, 8'h00, 32'h02);
      bus(1'b1, 8'h00, 32'h00);
      repeat (3) @(posedge mclk);
      bus(1'b0, 8'h00, 32'h0);
      chk("sys options", 32'h2, rd);
      chk("pull_up", 1'b1, pad_ctrl.pull_up[5]);
      chk("shared_port_in", 1'b0, shared_port_in);
      chk("shared_reset_req", 1'b0, shared_reset_req);
      sh_level <= 1'b0;
      repeat (5) @(posedge mclk);
      chk("shared_reset_req", 1'b1, shared_reset_req);
      sh_level <= 1'b1;
      do_reset(1'b0);
      chk("background_mode", 1'b0, background_mode);
      bus(1'b0, 8'h00, 32'h0);
      chk("sys options", 32'h3, rd);
   endtask
   task automatic t_background;
      hold_low <= 1'b1;
      do_reset(1'b1);
      chk("background_mode", 1'b1, background_mode);
      hold_low <= 1'b0;
      bus(1'b0, 8'h00, 32'h0);
      chk("sys options", 32'h3, rd);
      chk("pull_up", 6'h30, pad_ctrl.pull_up);
      debug_drive_low <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("debug wire", 2'b10, {debug_pin_oe, dbg_wire});
      debug_drive_low <= 1'b0;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      do_reset(1'b1);
      t_defaults;
      t_pads;
      t_keypad_irq;
      t_capture;
      t_reset_pin;
      t_background;
      tally_and_finish;
   end
   initial begin
      repeat (4000) @(posedge mclk);
      num_errors++;
      tally_and_finish;
   end
endmodule
